// ==== core/ccss_pkg.sv ====
// shared constants and types of the cpu clock source switcher
package ccss_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          CCSS_ADDR_W   = 4;
    localparam logic [1:0]  CCSS_IDX_CTRL = 2'h0;   // 0x00
    localparam logic [1:0]  CCSS_IDX_SEL  = 2'h1;   // 0x04
    localparam logic [1:0]  CCSS_IDX_STAT = 2'h2;   // 0x08

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int          CTL_MAIN_PIN  = 0;
    localparam int          CTL_MAIN_EXT  = 1;
    localparam int          CTL_MAIN_STOP = 2;
    localparam int          CTL_SUB_PIN   = 3;
    localparam int          CTL_SUB_EXT   = 4;
    localparam int          CTL_SUB_STOP  = 5;
    localparam int          CTL_FAST_STOP = 6;
    localparam logic [6:0]  CTL_RESET     = 7'h24;

    // ------------------------------------------------------------
    // select register and status fields
    // ------------------------------------------------------------
    localparam int          SEL_MAIN_HS   = 0;
    localparam int          SEL_SUB       = 1;
    localparam logic [1:0]  SEL_RESET     = 2'h0;
    localparam int          ST_MCS        = 0;
    localparam int          ST_CLS        = 1;
    localparam int          ST_BUSY       = 2;
    localparam int          ST_RDY_FAST   = 3;
    localparam int          ST_RDY_MAIN   = 4;
    localparam int          ST_RDY_SUB    = 5;

    // ------------------------------------------------------------
    // switching timing and bus answers
    // ------------------------------------------------------------
    localparam logic [3:0]  GAP_CYCLES    = 4'h4;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef enum logic [1:0] {
        SRC_FAST = 2'b00,
        SRC_MAIN = 2'b01,
        SRC_SUB  = 2'b10,
        SRC_NONE = 2'b11
    } ccss_src_e;

    typedef enum logic [1:0] {
        SW_IDLE  = 2'b00,
        SW_DESEL = 2'b01,
        SW_SEL   = 2'b10
    } ccss_sw_e;

endpackage

// ==== core/ccss_top.sv ====
// cpu clock source switcher with axi4-lite register slave
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps

module ccss_top
    import ccss_pkg::*;
(
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite write address and data
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [CCSS_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    // axi4-lite write response
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    output logic [1:0]                  s_axi_bresp,
    // axi4-lite read
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    input  wire logic [CCSS_ADDR_W-1:0] s_axi_araddr,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    // source ready pins (asynchronous)
    input  wire logic                   fast_osc_ready,
    input  wire logic                   main_osc_ready,
    input  wire logic                   sub_osc_ready,
    // oscillator enables and cpu clock mux select
    output logic                        fast_osc_enable,
    output logic                        main_crystal_osc_enable,
    output logic                        main_ext_input_enable,
    output logic                        sub_crystal_osc_enable,
    output logic                        sub_ext_input_enable,
    output logic [1:0]                  cpu_clock_select
);

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        aw_have;
        logic [3:0]  aw_addr;
        logic        w_have;
        logic [7:0]  w_data;
        logic        w_lane0;
        logic [6:0]  ctrl;
        logic [1:0]  clk_req;
        logic        main_clock_status;
        logic        cpu_clock_status;
        ccss_src_e   cur;
        ccss_src_e   sel;
        ccss_src_e   tgt;
        ccss_sw_e    sw;
        logic [3:0]  cnt;
        logic [2:0]  rdy_s1;
        logic [2:0]  rdy_s2;
        logic [4:0]  en;
    } ccss_state_s;

    ccss_state_s state_q;
    ccss_state_s state_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic src_ready(input ccss_src_e s, input logic [6:0] c,
                                       input logic [2:0] r);
        unique case (s)
            SRC_FAST: src_ready = r[0] & ~c[CTL_FAST_STOP];
            SRC_MAIN: src_ready = r[1] & c[CTL_MAIN_PIN] & ~c[CTL_MAIN_STOP];
            SRC_SUB:  src_ready = r[2] & c[CTL_SUB_PIN] & ~c[CTL_SUB_STOP];
            default:  src_ready = 1'b0;
        endcase
    endfunction

    function automatic logic [1:0] word_idx(input logic [3:0] a);
        word_idx = a[3:2];
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic       reject;
        logic [6:0] nc;
        ccss_src_e  want;
        reject = 1'b0;
        nc     = state_q.ctrl;
        want   = SRC_FAST;
        state_d = state_q;

        // two-flop synchronisers on the ready pins
        state_d.rdy_s1 = {sub_osc_ready, main_osc_ready, fast_osc_ready};
        state_d.rdy_s2 = state_q.rdy_s1;

        // write address and data taken in either order
        if (s_axi_awvalid && state_q.awready)
        begin
            state_d.aw_have = 1'b1;
            state_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_q.wready)
        begin
            state_d.w_have  = 1'b1;
            state_d.w_data  = s_axi_wdata[7:0];
            state_d.w_lane0 = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
            state_d.bvalid = 1'b0;

        if (state_q.aw_have && state_q.w_have && !state_q.bvalid)
        begin
            state_d.aw_have = 1'b0;
            state_d.w_have  = 1'b0;
            state_d.bvalid  = 1'b1;
            nc = state_q.w_data[6:0];
            unique case (word_idx(state_q.aw_addr))
                CCSS_IDX_CTRL:
                begin
                    // crystal and external input of the source in cur never swap; those of a switch target (tgt) can
                    if (state_q.cur == SRC_MAIN && !state_q.cpu_clock_status &&
                        (nc[CTL_MAIN_EXT] != state_q.ctrl[CTL_MAIN_EXT] ||
                         !nc[CTL_MAIN_PIN]))
                        reject = 1'b1;
                    if (state_q.cur == SRC_SUB &&
                        (nc[CTL_SUB_EXT] != state_q.ctrl[CTL_SUB_EXT] ||
                         !nc[CTL_SUB_PIN]))
                        reject = 1'b1;
                    // a stop aimed at the running source is refused
                    if ((nc[CTL_FAST_STOP] && state_q.sel == SRC_FAST) ||
                        (nc[CTL_MAIN_STOP] && state_q.sel == SRC_MAIN) ||
                        (nc[CTL_SUB_STOP] && state_q.sel == SRC_SUB) ||
                        (state_q.sw != SW_IDLE &&
                         ((nc[CTL_FAST_STOP] && state_q.tgt == SRC_FAST) ||
                          (nc[CTL_MAIN_STOP] && state_q.tgt == SRC_MAIN) ||
                          (nc[CTL_SUB_STOP] && state_q.tgt == SRC_SUB))))
                        reject = 1'b1;
                    if (reject)
                        state_d.bresp = RESP_SLVERR;
                    else
                    begin
                        state_d.bresp = RESP_OKAY;
                        if (state_q.w_lane0)
                            state_d.ctrl = nc;
                    end
                end
                CCSS_IDX_SEL:
                begin
                    state_d.bresp = RESP_OKAY;
                    if (state_q.w_lane0)
                        state_d.clk_req = state_q.w_data[1:0];
                end
                CCSS_IDX_STAT:
                    state_d.bresp = RESP_OKAY;
                default:
                    state_d.bresp = RESP_SLVERR;
            endcase
        end

        // read channel
        if (s_axi_rvalid && s_axi_rready)
            state_d.rvalid = 1'b0;
        if (s_axi_arvalid && state_q.arready)
        begin
            state_d.rvalid = 1'b1;
            state_d.rdata  = 32'h0;
            state_d.rresp  = RESP_OKAY;
            unique case (word_idx(s_axi_araddr))
                CCSS_IDX_CTRL: state_d.rdata[6:0] = state_q.ctrl;
                CCSS_IDX_SEL:  state_d.rdata[1:0] = state_q.clk_req;
                CCSS_IDX_STAT:
                begin
                    state_d.rdata[ST_MCS]      = state_q.main_clock_status;
                    state_d.rdata[ST_CLS]      = state_q.cpu_clock_status;
                    state_d.rdata[ST_BUSY]     = state_q.sw != SW_IDLE;
                    state_d.rdata[ST_RDY_FAST] = src_ready(SRC_FAST, state_q.ctrl,
                                                           state_q.rdy_s2);
                    state_d.rdata[ST_RDY_MAIN] = src_ready(SRC_MAIN, state_q.ctrl,
                                                           state_q.rdy_s2);
                    state_d.rdata[ST_RDY_SUB]  = src_ready(SRC_SUB, state_q.ctrl,
                                                           state_q.rdy_s2);
                end
                default: state_d.rresp = RESP_SLVERR;
            endcase
        end

        // --------------------------------------------------------
        // glitch-free source switch
        // --------------------------------------------------------
        if (state_q.clk_req[SEL_SUB])
            want = SRC_SUB;
        else if (state_q.clk_req[SEL_MAIN_HS])
            want = SRC_MAIN;
        else
            want = SRC_FAST;

        unique case (state_q.sw)
            SW_IDLE:
            begin
                // target must be enabled and settled before the mux moves;
                // a stop accepted in this same cycle must also hold it back
                if (want != state_q.cur &&
                    src_ready(want, state_d.ctrl, state_q.rdy_s2))
                begin
                    state_d.tgt = want;
                    state_d.sel = SRC_NONE;
                    state_d.cnt = 4'h0;
                    state_d.sw  = SW_DESEL;
                end
            end
            SW_DESEL:
            begin
                state_d.cnt = state_q.cnt + 4'h1;
                if (state_q.cnt == GAP_CYCLES - 4'h1)
                begin
                    state_d.sel = state_q.tgt;
                    state_d.cnt = 4'h0;
                    state_d.sw  = SW_SEL;
                end
            end
            SW_SEL:
            begin
                state_d.cnt = state_q.cnt + 4'h1;
                if (state_q.cnt == GAP_CYCLES - 4'h1)
                begin
                    // status only moves once the new source drives the cpu
                    state_d.cur = state_q.tgt;
                    state_d.cpu_clock_status = state_q.tgt == SRC_SUB;
                    if (state_q.tgt != SRC_SUB)
                        state_d.main_clock_status = state_q.tgt == SRC_MAIN;
                    state_d.sw  = SW_IDLE;
                end
            end
            default:
                state_d.sw = SW_IDLE;
        endcase

        // oscillator enables follow the stop and pin bits
        state_d.en[0] = ~state_d.ctrl[CTL_FAST_STOP];
        state_d.en[1] = state_d.ctrl[CTL_MAIN_PIN] & ~state_d.ctrl[CTL_MAIN_EXT]
                        & ~state_d.ctrl[CTL_MAIN_STOP];
        state_d.en[2] = state_d.ctrl[CTL_MAIN_PIN] & state_d.ctrl[CTL_MAIN_EXT]
                        & ~state_d.ctrl[CTL_MAIN_STOP];
        state_d.en[3] = state_d.ctrl[CTL_SUB_PIN] & ~state_d.ctrl[CTL_SUB_EXT]
                        & ~state_d.ctrl[CTL_SUB_STOP];
        state_d.en[4] = state_d.ctrl[CTL_SUB_PIN] & state_d.ctrl[CTL_SUB_EXT]
                        & ~state_d.ctrl[CTL_SUB_STOP];

        state_d.awready = ~state_d.aw_have & ~state_d.bvalid;
        state_d.wready  = ~state_d.w_have & ~state_d.bvalid;
        state_d.arready = ~state_d.rvalid;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q         <= '0;
            state_q.ctrl    <= CTL_RESET;
            state_q.clk_req <= SEL_RESET;
            state_q.cur     <= SRC_FAST;
            state_q.sel     <= SRC_FAST;
            state_q.tgt     <= SRC_FAST;
            state_q.sw      <= SW_IDLE;
            state_q.en      <= 5'h01;
        end
        else
            state_q <= state_d;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready           = state_q.awready;
    assign s_axi_wready            = state_q.wready;
    assign s_axi_bvalid            = state_q.bvalid;
    assign s_axi_bresp             = state_q.bresp;
    assign s_axi_arready           = state_q.arready;
    assign s_axi_rvalid            = state_q.rvalid;
    assign s_axi_rdata             = state_q.rdata;
    assign s_axi_rresp             = state_q.rresp;
    assign fast_osc_enable         = state_q.en[0];
    assign main_crystal_osc_enable = state_q.en[1];
    assign main_ext_input_enable   = state_q.en[2];
    assign sub_crystal_osc_enable  = state_q.en[3];
    assign sub_ext_input_enable    = state_q.en[4];
    assign cpu_clock_select        = state_q.sel;

endmodule

// ==== tb/ccss_assertions.sv ====
// assertions on the switcher top ports
`timescale 1ns/1ps
module ccss_assertions
    import ccss_pkg::*;
(
    // clock, reset and bus handshakes
    input wire logic        aclk, aresetn,
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic [31:0] s_axi_rdata,
    // oscillator enables and mux select
    input wire logic        fast_osc_enable, main_crystal_osc_enable, main_ext_input_enable,
    input wire logic        sub_crystal_osc_enable, sub_ext_input_enable,
    input wire logic [1:0]  cpu_clock_select
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence gap_entry;
        cpu_clock_select == SRC_NONE && $past(cpu_clock_select) != SRC_NONE;
    endsequence
    sequence gap_hold;
        (cpu_clock_select == SRC_NONE) [*3] ##1 cpu_clock_select != SRC_NONE;
    endsequence
    a_gap_length: assert property (gap_entry |=> gap_hold)
        else $error("mux gap has wrong length");
    a_gap_first: assert property (cpu_clock_select != SRC_NONE && $changed(cpu_clock_select) |-> $past(cpu_clock_select) == SRC_NONE)
        else $error("mux moved without a gap");
    a_fast_live: assert property (cpu_clock_select == SRC_FAST |-> fast_osc_enable)
        else $error("fast source stopped while selected");
    a_main_live: assert property (cpu_clock_select == SRC_MAIN |-> main_crystal_osc_enable || main_ext_input_enable)
        else $error("main source stopped while selected");
    a_sub_live: assert property (cpu_clock_select == SRC_SUB |-> sub_crystal_osc_enable || sub_ext_input_enable)
        else $error("sub source stopped while selected");
    a_main_excl: assert property (!(main_crystal_osc_enable && main_ext_input_enable))
        else $error("main crystal and input both on");
    a_sub_excl: assert property (!(sub_crystal_osc_enable && sub_ext_input_enable))
        else $error("sub crystal and input both on");
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer not after two edges");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
endmodule
bind ccss_top ccss_assertions u_ccss_chk (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_bresp(s_axi_bresp), .s_axi_rdata(s_axi_rdata),
    .fast_osc_enable(fast_osc_enable), .main_crystal_osc_enable(main_crystal_osc_enable),
    .main_ext_input_enable(main_ext_input_enable),
    .sub_crystal_osc_enable(sub_crystal_osc_enable),
    .sub_ext_input_enable(sub_ext_input_enable), .cpu_clock_select(cpu_clock_select)
);

// ==== tb/ccss_osc_model.sv ====
// oscillator and external clock model on the far side of the switcher
`timescale 1ns/1ps
module ccss_osc_model
#(
    parameter int SETTLE = 8
)
(
    // clock
    input  wire logic aclk,
    // enables from the switcher
    input  wire logic fast_osc_enable,
    input  wire logic main_crystal_osc_enable,
    input  wire logic main_ext_input_enable,
    input  wire logic sub_crystal_osc_enable,
    input  wire logic sub_ext_input_enable,
    // settled indications
    output logic      fast_osc_ready,
    output logic      main_osc_ready,
    output logic      sub_osc_ready
);
    logic [2:0] en;
    logic [2:0] ext;
    int         cnt [3] = '{0, 0, 0};
    assign en  = {sub_crystal_osc_enable | sub_ext_input_enable,
                  main_crystal_osc_enable | main_ext_input_enable, fast_osc_enable};
    assign ext = {sub_ext_input_enable, main_ext_input_enable, 1'b0};
    // crystals settle slowly, external inputs at once; a stopped source drops at once
    always @(posedge aclk)
        for (int i = 0; i < 3; i++)
            cnt[i] <= en[i] !== 1'b1 ? 0 : (ext[i] ? SETTLE : (cnt[i] < SETTLE ? cnt[i] + 1 : SETTLE));
    assign fast_osc_ready = cnt[0] == SETTLE;
    assign main_osc_ready = cnt[1] == SETTLE;
    assign sub_osc_ready  = cnt[2] == SETTLE;
endmodule

// ==== tb/cpu_clock_source_switcher_tb_top.sv ====
// self-checking bench for the cpu clock source switcher
`timescale 1ns/1ps
module cpu_clock_source_switcher_tb_top;
    import ccss_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, cpu_clock_select;
    logic        fast_osc_ready, main_osc_ready, sub_osc_ready, fast_osc_enable;
    logic        main_crystal_osc_enable, main_ext_input_enable;
    logic        sub_crystal_osc_enable, sub_ext_input_enable;
    int          failures = 0, num_checks = 0;
    logic [1:0]  wq [$];
    logic [33:0] rq [$];

    always #2.5 aclk = ~aclk;
    ccss_top dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .fast_osc_ready(fast_osc_ready), .main_osc_ready(main_osc_ready),
        .sub_osc_ready(sub_osc_ready),
        .fast_osc_enable(fast_osc_enable), .main_crystal_osc_enable(main_crystal_osc_enable),
        .main_ext_input_enable(main_ext_input_enable),
        .sub_crystal_osc_enable(sub_crystal_osc_enable),
        .sub_ext_input_enable(sub_ext_input_enable), .cpu_clock_select(cpu_clock_select)
    );
    ccss_osc_model #(.SETTLE(8)) u_osc (
        .aclk(aclk),
        .fast_osc_enable(fast_osc_enable), .main_crystal_osc_enable(main_crystal_osc_enable),
        .main_ext_input_enable(main_ext_input_enable),
        .sub_crystal_osc_enable(sub_crystal_osc_enable),
        .sub_ext_input_enable(sub_ext_input_enable),
        .fast_osc_ready(fast_osc_ready), .main_osc_ready(main_osc_ready),
        .sub_osc_ready(sub_osc_ready)
    );

    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // answers are compared against the oldest note as they are taken
    always @(posedge aclk)
    begin
        if (s_axi_bvalid && s_axi_bready)
            check(34'(s_axi_bresp), 34'(wq.pop_front()));
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    end

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        bit aw_done, w_done;
        aw_done = 0;
        w_done = 0;
        @(posedge aclk);
        wq.push_back(er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            aw_done |= s_axi_awready;
            w_done |= s_axi_wready;
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        // answer left waiting one cycle so its hold is exercised
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        rq.push_back({er, ed});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask

    // control write with random upper bits, then the enables it must produce
    task automatic ctl(input logic [6:0] v, input logic [1:0] er, input logic [4:0] en);
        wr(4'h0, {25'($urandom), v}, 4'hf, er);
        repeat (2) @(posedge aclk);
        check(34'({fast_osc_enable, main_crystal_osc_enable, main_ext_input_enable,
                   sub_crystal_osc_enable, sub_ext_input_enable}), 34'(en));
    endtask

    task automatic sel(input logic [1:0] v, input logic [31:0] st);
        int n;
        n = 0;
        wr(4'h4, {30'h0, v}, 4'hf, RESP_OKAY);
        while (cpu_clock_select !== v && n < 100)
        begin
            @(posedge aclk);
            n++;
        end
        check(34'(cpu_clock_select), 34'(v));
        repeat (6) @(posedge aclk);
        rd(4'h8, st, RESP_OKAY);
    endtask

    initial
    begin
        repeat (20000) @(posedge aclk);
        failures++;
        final_report();
    end

    initial
    begin
        void'($urandom(3));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (20) @(posedge aclk);
        rd(4'h0, 32'h24, RESP_OKAY);
        rd(4'h4, 32'h0, RESP_OKAY);
        rd(4'h8, 32'h08, RESP_OKAY);
        rd(4'hc, 32'h0, RESP_SLVERR);
        wr(4'hc, 32'h7f, 4'hf, RESP_SLVERR);
        ctl(7'h21, RESP_OKAY, 5'b11000);
        sel(2'h1, 32'h19);
        ctl(7'h23, RESP_SLVERR, 5'b11000);
        ctl(7'h25, RESP_SLVERR, 5'b11000);
        ctl(7'h61, RESP_OKAY, 5'b01000);
        ctl(7'h59, RESP_OKAY, 5'b01001);
        sel(2'h2, 32'h33);
        ctl(7'h79, RESP_SLVERR, 5'b01001);
        ctl(7'h5d, RESP_OKAY, 5'b00001);
        ctl(7'h1d, RESP_OKAY, 5'b10001);
        sel(2'h0, 32'h28);
        ctl(7'h3d, RESP_OKAY, 5'b10000);
        ctl(7'h03, RESP_OKAY, 5'b10100);
        sel(2'h1, 32'h19);
        sel(2'h0, 32'h18);
        ctl(7'h07, RESP_OKAY, 5'b10000);
        // fast stop kept clear: the stop check runs even with no lane written
        wr(4'h0, $urandom & 32'hffffffbf, 4'h0, RESP_OKAY);
        rd(4'h0, 32'h07, RESP_OKAY);
        @(posedge aclk);
        final_report();
    end
endmodule
